// ===== shared/ccs_pkg.sv
// Package with constants and carrier types for the charge cycle sequencer.
package ccs_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_HZ       = 1_000;
  localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
  localparam int unsigned DEGLITCH_MS   = 5;
  localparam int unsigned RECHARGE_MS   = 4;
  localparam int unsigned DEGLITCH_TK   = DEGLITCH_MS * TICK_HZ / 1000;
  localparam int unsigned RECHARGE_TK   = RECHARGE_MS * TICK_HZ / 1000;
  localparam int unsigned FLASH_MS      = 666;
  localparam int unsigned PULSE_MS      = 333;
  localparam int unsigned FLASH_TK      = FLASH_MS * TICK_HZ / 1000;
  localparam int unsigned PULSE_TK      = PULSE_MS * TICK_HZ / 1000;
  localparam int unsigned TOTAL_TK_DEF  = 10_800_000;
  localparam int unsigned TRICKLE_SHIFT = 2;
  localparam int unsigned RECHG_SHIFT   = 1;
  localparam int unsigned QUAL_W        = 4;
  localparam int unsigned FLASH_W       = 10;
  localparam int unsigned TIMER_W       = 24;
  localparam int unsigned DIV_W         = 17;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCS_STATUS_OFF,
    CCS_STATUS_STRONG,
    CCS_STATUS_WEAK
  } ccs_status_e;

  typedef enum {
    CCS_IDLE,
    CCS_TRICKLE,
    CCS_FAST,
    CCS_DONE,
    CCS_STOPPED
  } ccs_state_e;

  // Raw comparator results from the analog front end.
  typedef struct packed {
    logic uvlo_ok;
    logic supply_margin;
    logic below_precond;
    logic below_short;
    logic over_volt;
    logic over_volt_clear;
    logic below_restart;
    logic near_float;
    logic taper_below;
    logic temp_fault;
  } ccs_cmp_s;

  // Charger drive controls.
  typedef struct packed {
    logic linear_on;
    logic switch_on;
  } ccs_drive_s;

endpackage : ccs_pkg

// ===== sim/ccs_chk.sv
// Concurrent checks on the ports of the charge cycle sequencer.
`timescale 1ns/100ps

module ccs_chk #(
  parameter int unsigned TOTAL_TICKS = 40, // Total charge time in ticks
  parameter int unsigned TICK_CYCLES = 4   // Clocks in one tick
) (
  input wire logic                i_clk,          // Clock
  input wire logic                i_reset_n,      // Reset, active low
  input wire logic                i_disable_n_hi, // Disable pin
  input wire ccs_pkg::ccs_cmp_s   i_cmp,          // Comparator results
  input wire ccs_pkg::ccs_drive_s o_drive,        // Charger enables
  input wire ccs_pkg::ccs_status_e o_status,      // Status drive mode
  input wire logic                o_status_oe,    // Status pin sinking
  input wire logic                o_batt_error    // Battery error
);
  import ccs_pkg::*;

  // Run lengths of raw conditions; lags of the design only shorten them.
  int ok_q, tap_q, tmp_q, lin_q, on_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ok_q <= 0;
      tap_q <= 0;
      tmp_q <= 0;
      lin_q <= 0;
      on_q <= 0;
    end else begin
      // Supply qualification runs apart from the disable pin, so a
      // release of disable after a long good supply may start at once.
      ok_q <= (i_cmp.uvlo_ok && i_cmp.supply_margin) ? ok_q + 1 : 0;
      tap_q <= i_cmp.taper_below ? tap_q + 1 : 0;
      tmp_q <= i_cmp.temp_fault ? tmp_q + 1 : 0;
      lin_q <= (o_drive.linear_on && !i_cmp.below_short) ? lin_q + 1 : 0;
      on_q <= (o_status == CCS_STATUS_OFF) ? 0 :
              (o_drive != 2'h0) ? on_q + 1 : on_q;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_drive_excl: assert property (
    !(o_drive.linear_on && o_drive.switch_on)) else $error("both on");
  a_off_no_sink: assert property (
    o_status == CCS_STATUS_OFF |-> !o_status_oe) else $error("off sinks");
  a_disable_stop: assert property (
    i_disable_n_hi[*6] |-> o_drive == 2'h0) else $error("disable ignored");
  a_start_qual: assert property (
    $rose(o_drive != 2'h0) |-> ok_q >= 4 * TICK_CYCLES)
    else $error("start not qualified");
  a_weak_qual: assert property (
    $rose(o_status == CCS_STATUS_WEAK) |-> tap_q >= 4 * TICK_CYCLES)
    else $error("weak too early");
  a_short_lin: assert property (
    i_cmp.below_short[*8] |-> !o_drive.switch_on &&
    (!o_drive.linear_on || o_batt_error)) else $error("short mishandled");
  a_ovp_off: assert property (
    i_cmp.over_volt[*6] |-> o_drive == 2'h0) else $error("ovp ignored");
  a_temp_off: assert property (
    tmp_q >= 6 * TICK_CYCLES + 6 |-> o_drive == 2'h0 && o_batt_error)
    else $error("temp fault ignored");
  a_trickle_lim: assert property (
    lin_q <= (TOTAL_TICKS / 4 + 2) * TICK_CYCLES) else $error("trickle long");
  a_timer_lim: assert property (
    on_q <= (TOTAL_TICKS + 2) * TICK_CYCLES) else $error("timer overrun");
endmodule : ccs_chk

bind ccs_sequencer ccs_chk #(
  .TOTAL_TICKS(TOTAL_TICKS),
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_disable_n_hi(i_disable_n_hi),
  .i_cmp(i_cmp),
  .o_drive(o_drive),
  .o_status(o_status),
  .o_status_oe(o_status_oe),
  .o_batt_error(o_batt_error)
);

// ===== sim/ccs_env_model.sv
// Model of the adapter, battery and thermistor as seen by the comparators.
`timescale 1ns/100ps

module ccs_env_model #(
  parameter int UVLO_MV  = 2750, // Lockout release level
  parameter int MARGIN_MV = 250, // Supply over battery to start
  parameter int PRE_MV   = 3000, // Precondition threshold
  parameter int SHORT_MV = 1800, // Shorted cell level
  parameter int FLOAT_MV = 4200  // Float voltage
) (
  input  wire logic [15:0]  i_supply_mv, // Adapter voltage in mV
  input  wire logic [15:0]  i_batt_mv,   // Battery voltage in mV
  input  wire logic         i_taper,     // Charge current under taper level
  input  wire logic         i_temp_bad,  // Thermistor outside its window
  output ccs_pkg::ccs_cmp_s o_cmp        // Comparator results
);
  import ccs_pkg::*;

  // Levels are compared in plain integers so no width can wrap.
  int sup;
  int bat;
  assign sup = int'(i_supply_mv);
  assign bat = int'(i_batt_mv);
  assign o_cmp.uvlo_ok = sup > UVLO_MV;
  assign o_cmp.supply_margin = sup > bat + MARGIN_MV;
  assign o_cmp.below_precond = bat < PRE_MV;
  assign o_cmp.below_short = bat < SHORT_MV;
  assign o_cmp.over_volt = bat > FLOAT_MV * 105 / 100;
  assign o_cmp.over_volt_clear = bat < FLOAT_MV * 104 / 100;
  assign o_cmp.below_restart = bat < FLOAT_MV - 100;
  assign o_cmp.near_float = bat >= FLOAT_MV - 100;
  assign o_cmp.taper_below = i_taper;
  assign o_cmp.temp_fault = i_temp_bad;
endmodule : ccs_env_model

// ===== sim/tb.sv
// Self-checking testbench for the charge cycle sequencer.
`timescale 1ns/100ps

module tb;
  import ccs_pkg::*;
  localparam int unsigned TT = 40;
  localparam int unsigned TC = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dis = 1'b1;
  logic        taper = 1'b0;
  logic        hot = 1'b0;
  logic [15:0] sup_mv = 16'h1388;
  logic [15:0] bat_mv = 16'h09C4;
  ccs_cmp_s    cmp;
  ccs_drive_s  drv;
  ccs_status_e st;
  logic        oe;
  logic        err;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          waited;

  always #5 clk = ~clk;

  ccs_env_model i_env (.i_supply_mv(sup_mv), .i_batt_mv(bat_mv),
    .i_taper(taper), .i_temp_bad(hot), .o_cmp(cmp));
  ccs_sequencer #(.TOTAL_TICKS(TT), .TICK_CYCLES(TC)) i_dut (.i_clk(clk),
    .i_reset_n(rst_n), .i_disable_n_hi(dis), .i_cmp(cmp), .o_drive(drv),
    .o_status(st), .o_status_oe(oe), .o_batt_error(err));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [3:0] exp,
                     input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Bits are {linear, switch, status}; the mask picks what must match.
  task automatic wait_out(input logic [3:0] want, input logic [3:0] msk,
                          input int lim);
    waited = 0;
    // Look away from the launching edge so outputs have settled.
    @(negedge clk);
    while ((({drv, st} & msk) !== want) && waited < lim) begin
      @(negedge clk);
      waited++;
    end
    if (waited >= lim) begin
      bad_count++;
      $display("[ERR] wait expected %h seen %h", want, {drv, st});
      end_of_test();
    end
  endtask : wait_out

  task automatic restart(input logic [15:0] mv);
    @(posedge clk);
    bat_mv <= mv;
    dis <= 1'b1;
    repeat (5) @(posedge clk);
    dis <= 1'b0;
  endtask : restart

  task automatic t_main();
    repeat (10 * TC) @(negedge clk);
    chk("refused", 4'h0, {drv, st});
    @(posedge clk);
    dis <= 1'b0;
    wait_out(4'h9, 4'hF, 10 * TC);
    chk("error", 4'h0, {3'h0, err});
    chk("sink", 4'h1, {3'h0, oe});
    @(posedge clk);
    bat_mv <= 16'h0DAC;
    repeat (3 * TC) @(negedge clk);
    chk("deglitch", 4'h9, {drv, st});
    wait_out(4'h5, 4'hF, 4 * TC);
    @(posedge clk);
    bat_mv <= 16'h1036;
    taper <= 1'b1;
    repeat (3 * TC) @(negedge clk);
    chk("taper early", 4'h1, {2'h0, st});
    wait_out(4'h2, 4'h3, 4 * TC);
    @(posedge clk);
    taper <= 1'b0;
    repeat (8 * TC) @(negedge clk);
    chk("weak latch", 4'h2, {2'h0, st});
    chk("weak sink", 4'h1, {3'h0, oe});
    wait_out(4'h0, 4'hF, TT * TC);
    chk("off sink", 4'h0, {3'h0, oe});
    @(posedge clk);
    bat_mv <= 16'h0FD2;
    wait_out(4'h4, 4'hC, 8 * TC);
    chk("restart qual", 4'h1, {3'h0, waited >= 3 * TC});
    wait_out(4'h0, 4'hF, TT * TC);
    chk("half time", 4'h1, {3'h0, waited <= (TT / 2 + 2) * TC});
    $display("test main cycle done");
  endtask : t_main

  task automatic t_faults();
    restart(16'h0DAC);
    wait_out(4'h5, 4'hF, 10 * TC);
    @(posedge clk);
    hot <= 1'b1;
    repeat (3 * TC) @(negedge clk);
    chk("temp early", 4'h4, {drv, 2'h0});
    wait_out(4'h0, 4'hC, 5 * TC);
    chk("temp error", 4'h1, {3'h0, err});
    chk("temp blink", 4'h1, {2'h0, st});
    @(posedge clk);
    hot <= 1'b0;
    wait_out(4'h4, 4'hC, 10 * TC);
    @(posedge clk);
    bat_mv <= 16'h1194;
    wait_out(4'h0, 4'hC, 4 * TC);
    @(posedge clk);
    bat_mv <= 16'h111C;
    repeat (3 * TC) @(negedge clk);
    chk("ovp hyst", 4'h0, {drv, 2'h0});
    @(posedge clk);
    bat_mv <= 16'h10CC;
    wait_out(4'h4, 4'hC, 4 * TC);
    restart(16'h05DC);
    wait_out(4'h8, 4'hC, 10 * TC);
    repeat (2 * TC) @(negedge clk);
    chk("short drive", 4'h8, {drv, 2'h0});
    chk("short error", 4'h1, {3'h0, err});
    restart(16'h09C4);
    wait_out(4'h8, 4'hC, 10 * TC);
    wait_out(4'h0, 4'hC, (TT / 4 + 2) * TC);
    chk("trickle error", 4'h1, {3'h0, err});
    $display("test faults done");
  endtask : t_faults

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_main();
    t_faults();
    end_of_test();
  end
endmodule : tb

// ===== src/ccs_sequencer.sv
// Charge cycle sequencer: qualification, mode choice, timers and status.
`timescale 1ns/100ps

module ccs_sequencer #(
  parameter int unsigned TOTAL_TICKS = ccs_pkg::TOTAL_TK_DEF, // Total time, ms
  parameter int unsigned TICK_CYCLES = ccs_pkg::TICK_DIV      // Clocks a tick
) (
  input  wire logic              i_clk,          // System clock
  input  wire logic              i_reset_n,      // Async reset, active low
  input  wire logic              i_disable_n_hi, // Disable pin, high stops
  input  wire ccs_pkg::ccs_cmp_s i_cmp,          // Comparator results
  output ccs_pkg::ccs_drive_s    o_drive,        // Charger enables
  output ccs_pkg::ccs_status_e   o_status,       // Status pin drive mode
  output logic                   o_status_oe,    // Status pin sinking now
  output logic                   o_batt_error    // Battery error level
);
  import ccs_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  localparam int unsigned NIN = $bits(ccs_cmp_s) + 1;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;
  logic [NIN-1:0] meta_d;
  logic [NIN-1:0] sync_d;
  always_comb begin
    meta_d = {i_disable_n_hi, i_cmp};
    sync_d = meta_q;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  ccs_cmp_s cmp;
  logic     dis_s;
  always_comb begin
    cmp   = sync_q[NIN-2:0];
    dis_s = sync_q[NIN-1];
  end

  // ---------------------------------------------------------------------------
  // Tick divider
  // ---------------------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic             tick;
  always_comb begin
    tick  = (div_q == DIV_W'(TICK_CYCLES - 1));
    div_d = tick ? '0 : div_q + 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) div_q <= '0;
    else div_q <= div_d;
  end

  // ---------------------------------------------------------------------------
  // Deglitch qualifiers: supply, rise past precondition, taper, thermistor,
  // restart. Taper and thermistor qualify both edges; a lapse restarts.
  // ---------------------------------------------------------------------------
  localparam int unsigned NQ = 5;
  logic [NQ-1:0]        q_raw;
  logic [NQ-1:0]        q_both;
  logic [NQ-1:0][QUAL_W-1:0] q_lim;
  logic [NQ-1:0]        qual_q;
  logic [NQ-1:0]        qual_d;
  logic [NQ-1:0][QUAL_W-1:0] qcnt_q;
  logic [NQ-1:0][QUAL_W-1:0] qcnt_d;
  always_comb begin
    q_raw  = {cmp.below_restart, cmp.temp_fault,
              cmp.taper_below & cmp.near_float,
              ~cmp.below_precond,
              cmp.uvlo_ok & cmp.supply_margin};
    q_both = 5'b0_1100;
    q_lim  = {QUAL_W'(RECHARGE_TK), {4{QUAL_W'(DEGLITCH_TK)}}};
  end

  generate
    for (genvar g = 0; g < NQ; g++) begin : g_qual
      always_comb begin
        qual_d[g] = qual_q[g];
        qcnt_d[g] = qcnt_q[g];
        if (q_raw[g] == qual_q[g] || (!q_raw[g] && !q_both[g])) begin
          qcnt_d[g] = '0;
          qual_d[g] = q_both[g] ? qual_q[g] : q_raw[g];
        end else if (tick) begin
          if (qcnt_q[g] + 1'b1 >= q_lim[g]) begin
            qual_d[g] = q_raw[g];
            qcnt_d[g] = '0;
          end else begin
            qcnt_d[g] = qcnt_q[g] + 1'b1;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qual_q <= '0;
      qcnt_q <= '0;
    end else begin
      qual_q <= qual_d;
      qcnt_q <= qcnt_d;
    end
  end

  logic supply_ok;
  logic precond_ok;
  logic taper_ok;
  logic temp_bad;
  logic restart_ok;
  always_comb begin
    supply_ok  = qual_q[0];
    precond_ok = qual_q[1];
    taper_ok   = qual_q[2];
    temp_bad   = qual_q[3];
    restart_ok = qual_q[4];
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  ccs_state_e         st_q;
  ccs_state_e         st_d;
  logic [TIMER_W-1:0] tmr_q;
  logic [TIMER_W-1:0] tmr_d;
  logic               rechg_q;
  logic               rechg_d;
  logic               weak_q;
  logic               weak_d;
  logic               trk_err_q;
  logic               trk_err_d;
  logic               ovp_q;
  logic               ovp_d;
  logic [TIMER_W-1:0] limit;
  logic [TIMER_W-1:0] trk_limit;
  logic               can_start;
  always_comb begin
    limit     = rechg_q ? TIMER_W'(TOTAL_TICKS >> RECHG_SHIFT)
                        : TIMER_W'(TOTAL_TICKS);
    trk_limit = TIMER_W'(TOTAL_TICKS >> TRICKLE_SHIFT);
    can_start = supply_ok && !dis_s;
    st_d      = st_q;
    tmr_d     = tmr_q;
    rechg_d   = rechg_q;
    weak_d    = weak_q;
    trk_err_d = trk_err_q;
    ovp_d     = ovp_q;
    if (cmp.over_volt) ovp_d = 1'b1;
    else if (cmp.over_volt_clear) ovp_d = 1'b0;
    // Disable or supply loss aborts any cycle; release restarts fresh.
    if (!can_start) begin
      st_d = CCS_IDLE;
    end else begin
      case (st_q)
        CCS_IDLE: begin
          tmr_d     = '0;
          rechg_d   = 1'b0;
          weak_d    = 1'b0;
          trk_err_d = 1'b0;
          st_d      = cmp.below_precond ? CCS_TRICKLE : CCS_FAST;
        end
        CCS_TRICKLE, CCS_FAST: begin
          // The timer holds during a temperature fault.
          if (tick && !temp_bad) tmr_d = tmr_q + 1'b1;
          if (st_q == CCS_FAST && taper_ok) weak_d = 1'b1;
          if (tmr_q >= limit) begin
            st_d = CCS_DONE;
          end else if (st_q == CCS_TRICKLE && tmr_q >= trk_limit) begin
            st_d      = CCS_STOPPED;
            trk_err_d = 1'b1;
          end else if (st_q == CCS_TRICKLE && precond_ok) begin
            st_d = CCS_FAST;
          end
        end
        CCS_DONE: begin
          if (restart_ok) begin
            st_d    = CCS_FAST;
            tmr_d   = '0;
            rechg_d = 1'b1;
            weak_d  = 1'b0;
          end
        end
        CCS_STOPPED: st_d = CCS_STOPPED;
        default: st_d = CCS_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q      <= CCS_IDLE;
      tmr_q     <= '0;
      rechg_q   <= 1'b0;
      weak_q    <= 1'b0;
      trk_err_q <= 1'b0;
      ovp_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      tmr_q     <= tmr_d;
      rechg_q   <= rechg_d;
      weak_q    <= weak_d;
      trk_err_q <= trk_err_d;
      ovp_q     <= ovp_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Blink generator and outputs
  // ---------------------------------------------------------------------------
  logic [FLASH_W-1:0] fl_q;
  logic [FLASH_W-1:0] fl_d;
  ccs_drive_s         drv_d;
  ccs_status_e        stat_d;
  logic               oe_d;
  logic               err_d;
  logic               charging;
  always_comb begin
    fl_d = fl_q;
    if (!temp_bad) fl_d = '0;
    else if (tick) fl_d = (fl_q == FLASH_W'(FLASH_TK - 1)) ? '0 : fl_q + 1'b1;
    charging  = (st_q == CCS_TRICKLE || st_q == CCS_FAST);
    drv_d     = '0;
    if (charging && !temp_bad && !ovp_q) begin
      // Short circuit keeps the battery on the trickle current.
      drv_d.linear_on = (st_q == CCS_TRICKLE) || cmp.below_short;
      drv_d.switch_on = (st_q == CCS_FAST) && !cmp.below_short;
    end
    stat_d = CCS_STATUS_OFF;
    if (charging && temp_bad) begin
      stat_d = (fl_q < FLASH_W'(PULSE_TK)) ? CCS_STATUS_STRONG
                                           : CCS_STATUS_OFF;
    end else if (charging) begin
      stat_d = weak_q ? CCS_STATUS_WEAK : CCS_STATUS_STRONG;
    end
    oe_d  = (stat_d != CCS_STATUS_OFF);
    err_d = trk_err_q || (can_start && (cmp.below_short || temp_bad));
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fl_q         <= '0;
      o_drive      <= '0;
      o_status     <= CCS_STATUS_OFF;
      o_status_oe  <= 1'b0;
      o_batt_error <= 1'b0;
    end else begin
      fl_q         <= fl_d;
      o_drive      <= drv_d;
      o_status     <= stat_d;
      o_status_oe  <= oe_d;
      o_batt_error <= err_d;
    end
  end

endmodule : ccs_sequencer
